// >>> rtl/sbau_pkg.sv
// Package for the 16-bit arithmetic unit: opcodes, prefixes, pair codes, flag
// positions inside the unit's flag port and clock-state counts per instruction.
// Assumes the core feeds opcode bytes one at a time on the core clock.
package sbau_pkg;

  localparam logic [7:0] SBAU_PFX_EXT    = 8'hED;
  localparam logic [7:0] SBAU_PFX_IDX1   = 8'hDD;
  localparam logic [7:0] SBAU_PFX_IDX2   = 8'hFD;
  localparam logic [7:0] SBAU_OP_IDX_INC = 8'h23;
  localparam logic [7:0] SBAU_OP_IDX_DEC = 8'h2B;

  // Low nibble patterns with pair field in bits 5:4
  localparam logic [3:0] SBAU_LO_ADD = 4'h9;
  localparam logic [3:0] SBAU_LO_INC = 4'h3;
  localparam logic [3:0] SBAU_LO_DEC = 4'hB;
  localparam logic [3:0] SBAU_LO_ADC = 4'hA;
  localparam logic [3:0] SBAU_LO_SUBB = 4'h2;
  localparam logic [1:0] SBAU_HI_PLAIN = 2'h0;
  localparam logic [1:0] SBAU_HI_EXT   = 2'h1;

  localparam logic [1:0] SBAU_PAIR_FIRST  = 2'h0;
  localparam logic [1:0] SBAU_PAIR_SECOND = 2'h1;
  localparam logic [1:0] SBAU_PAIR_PTR    = 2'h2;
  localparam logic [1:0] SBAU_PAIR_STACK  = 2'h3;

  // Flag vector bit positions (unit-local order)
  localparam int SBAU_F_C  = 0;
  localparam int SBAU_F_N  = 1;
  localparam int SBAU_F_PV = 2;
  localparam int SBAU_F_H  = 3;
  localparam int SBAU_F_Z  = 4;
  localparam int SBAU_F_S  = 5;

  // Total clock states and M cycles per instruction, counted from the first opcode byte
  localparam logic [4:0] SBAU_T_ADD     = 5'h0B;
  localparam logic [4:0] SBAU_T_CARRY   = 5'h0F;
  localparam logic [4:0] SBAU_T_IDX_ADD = 5'h0F;
  localparam logic [4:0] SBAU_T_INCDEC  = 5'h06;
  localparam logic [4:0] SBAU_T_IDX_ID  = 5'h0A;
  localparam logic [2:0] SBAU_M_ADD     = 3'h3;
  localparam logic [2:0] SBAU_M_LONG    = 3'h4;
  localparam logic [2:0] SBAU_M_INCDEC  = 3'h1;
  localparam logic [2:0] SBAU_M_IDX_ID  = 3'h2;

  localparam logic [15:0] SBAU_REG_RST = 16'h0000;
  localparam logic [5:0]  SBAU_FLAG_RST = 6'h00;

endpackage

// >>> rtl/sbau_unit.sv
// 16-bit arithmetic unit: decodes prefixed and plain opcode bytes, holds the
// six 16-bit registers and the flag vector, and executes after a state count.
// Assumes op_valid bytes come only while busy is low, or in the byte after a prefix.
//
// Overview of operation
// - Byte 00pp1001 adds selected pair into pointer pair, 3 M cycles, 11 states.
// - Pair field codes: 00 first pair, 01 second, 10 pointer pair, 11 stack.
// - Plain 16-bit adds set half-carry from bit 11 and carry from bit 15.
// - Plain 16-bit adds keep sign, zero, parity/overflow; clear subtract flag.
// - ED then 01pp1010 adds pair plus carry into pointer pair, 15 states.
// - Carry add and borrow subtract set sign, zero and overflow from result.
// - Carry add clears subtract, sets half-carry bit 11, carry bit 15.
// - ED then 01pp0010 subtracts pair and carry from pointer pair, 15 states.
// - Borrow subtract sets subtract flag, half-carry on bit-12 borrow, carry on borrow.
// - Borrow subtract sets subtract flag and sets carry on borrow.
// - DD then 00pp1001 adds pair into first index; code 10 means itself.
// - FD then 00pp1001 adds pair into second index; code 10 means itself.
// - Byte 00pp0011 increments selected pair, 1 M cycle, 6 states.
// - Byte 00pp1011 decrements selected pair, 1 M cycle, 6 states.
// - Increments and decrements leave all flags unchanged.
// - DD or FD then 23 increments the index register, 10 states.
// - DD or FD then 2B decrements the index register, 10 states.
`timescale 1ns/1ps

module sbau_unit
  import sbau_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_byte,
  output logic             busy,
  output logic             done,
  output logic             illegal,
  output logic [2:0]       m_cycles,
  output logic [4:0]       t_states,
  output logic [15:0]      first_general_pair,
  output logic [15:0]      second_general_pair,
  output logic [15:0]      primary_pointer_pair,
  output logic [15:0]      stack_pointer,
  output logic [15:0]      first_index_reg,
  output logic [15:0]      second_index_reg,
  output logic [5:0]       flags
);

  typedef enum logic [1:0] {SBAU_IDLE, SBAU_PFX, SBAU_EXEC} sbau_state_t;
  typedef enum logic [2:0] {
    SBAU_K_ADD, SBAU_K_ADC, SBAU_K_SUBB, SBAU_K_INC, SBAU_K_DEC
  } sbau_kind_t;

  typedef struct packed {
    sbau_state_t  st;
    logic [1:0]   pfx;       // 0 none, 1 ext, 2 first index, 3 second index
    sbau_kind_t   kind;
    logic [2:0]   dst;       // 0..3 pair codes, 4 first index, 5 second index
    logic [2:0]   src;
    logic [4:0]   cnt;
    logic         busy;
    logic         done;
    logic         illegal;
    logic [2:0]   m_cycles;
    logic [4:0]   t_states;
    logic [15:0]  r_gen1, r_gen2, r_ptr, r_stk, r_idx1, r_idx2;
    logic [5:0]   flags;
  } sbau_regs_t;

  sbau_regs_t q;
  sbau_regs_t next_q;

  function automatic logic [15:0] sbau_rd(input sbau_regs_t s, input logic [2:0] i);
    logic [15:0] v;
    v = 16'h0000;
    unique case (i)
      3'h0: v = s.r_gen1;
      3'h1: v = s.r_gen2;
      3'h2: v = s.r_ptr;
      3'h3: v = s.r_stk;
      3'h4: v = s.r_idx1;
      default: v = s.r_idx2;
    endcase
    return v;
  endfunction

  logic [15:0] a_val, b_val, res;
  logic [16:0] sum17;
  logic [12:0] low13;
  logic        cin;

  always_comb
  begin
    a_val = sbau_rd(q, q.dst);
    b_val = sbau_rd(q, q.src);
    cin   = (q.kind == SBAU_K_ADC || q.kind == SBAU_K_SUBB) ? q.flags[SBAU_F_C] : 1'b0;
    sum17 = 17'h00000;
    low13 = 13'h0000;
    res   = 16'h0000;
    unique case (q.kind)
      SBAU_K_SUBB:
      begin
        sum17 = {1'b0, a_val} - {1'b0, b_val} - {16'h0000, cin};
        low13 = {1'b0, a_val[11:0]} - {1'b0, b_val[11:0]} - {12'h000, cin};
      end
      SBAU_K_INC: sum17 = {1'b0, a_val} + 17'h00001;
      SBAU_K_DEC: sum17 = {1'b0, a_val} - 17'h00001;
      default:
      begin
        sum17 = {1'b0, a_val} + {1'b0, b_val} + {16'h0000, cin};
        low13 = {1'b0, a_val[11:0]} + {1'b0, b_val[11:0]} + {12'h000, cin};
      end
    endcase
    res = sum17[15:0];
  end

  // Decode one opcode byte; returns kind, operands, timing and a legal bit
  logic        d_ok;
  sbau_kind_t  d_kind;
  logic [2:0]  d_dst, d_src;
  logic [4:0]  d_t;
  logic [2:0]  d_m;
  logic [2:0]  d_ptr;

  always_comb
  begin
    d_ok   = 1'b0;
    d_kind = SBAU_K_ADD;
    d_m    = SBAU_M_ADD;
    d_t    = SBAU_T_ADD;
    d_ptr  = (q.pfx == 2'h2) ? 3'h4 : (q.pfx == 2'h3) ? 3'h5 : 3'h2;
    d_dst  = d_ptr;
    // code 10 names the register under modification
    d_src  = (op_byte[5:4] == SBAU_PAIR_PTR) ? d_ptr : {1'b0, op_byte[5:4]};
    if (q.pfx == 2'h1)
    begin
      if (op_byte[7:6] == SBAU_HI_EXT && op_byte[3:0] == SBAU_LO_ADC)
      begin
        d_ok = 1'b1; d_kind = SBAU_K_ADC; d_m = SBAU_M_LONG; d_t = SBAU_T_CARRY;
      end
      else if (op_byte[7:6] == SBAU_HI_EXT && op_byte[3:0] == SBAU_LO_SUBB)
      begin
        d_ok = 1'b1; d_kind = SBAU_K_SUBB; d_m = SBAU_M_LONG; d_t = SBAU_T_CARRY;
      end
    end
    else if (q.pfx != 2'h0)
    begin
      if (op_byte[7:6] == SBAU_HI_PLAIN && op_byte[3:0] == SBAU_LO_ADD)
      begin
        d_ok = 1'b1; d_m = SBAU_M_LONG; d_t = SBAU_T_IDX_ADD;
      end
      else if (op_byte == SBAU_OP_IDX_INC || op_byte == SBAU_OP_IDX_DEC)
      begin
        d_ok   = 1'b1;
        d_kind = (op_byte == SBAU_OP_IDX_INC) ? SBAU_K_INC : SBAU_K_DEC;
        d_m    = SBAU_M_IDX_ID;
        d_t    = SBAU_T_IDX_ID;
      end
    end
    else if (op_byte[7:6] == SBAU_HI_PLAIN)
    begin
      d_dst = {1'b0, op_byte[5:4]};
      if (op_byte[3:0] == SBAU_LO_ADD)
      begin
        d_ok = 1'b1; d_dst = 3'h2;
      end
      else if (op_byte[3:0] == SBAU_LO_INC || op_byte[3:0] == SBAU_LO_DEC)
      begin
        d_ok   = 1'b1;
        d_kind = (op_byte[3:0] == SBAU_LO_INC) ? SBAU_K_INC : SBAU_K_DEC;
        d_m    = SBAU_M_INCDEC;
        d_t    = SBAU_T_INCDEC;
      end
    end
  end

  always_comb
  begin
    next_q         = q;
    next_q.done    = 1'b0;
    next_q.illegal = 1'b0;
    unique case (q.st)
      SBAU_IDLE, SBAU_PFX:
      begin
        if (op_valid)
        begin
          if (q.st == SBAU_IDLE && op_byte == SBAU_PFX_EXT)
          begin
            next_q.st = SBAU_PFX; next_q.pfx = 2'h1; next_q.busy = 1'b1;
          end
          else if (q.st == SBAU_IDLE && op_byte == SBAU_PFX_IDX1)
          begin
            next_q.st = SBAU_PFX; next_q.pfx = 2'h2; next_q.busy = 1'b1;
          end
          else if (q.st == SBAU_IDLE && op_byte == SBAU_PFX_IDX2)
          begin
            next_q.st = SBAU_PFX; next_q.pfx = 2'h3; next_q.busy = 1'b1;
          end
          else if (d_ok)
          begin
            next_q.st       = SBAU_EXEC;
            next_q.kind     = d_kind;
            next_q.dst      = d_dst;
            next_q.src      = d_src;
            next_q.m_cycles = d_m;
            next_q.t_states = d_t;
            next_q.busy     = 1'b1;
            // Prefix byte already spent four states
            next_q.cnt      = (q.pfx != 2'h0) ? 5'(d_t - 5'h05) : 5'(d_t - 5'h01);
          end
          else
          begin
            next_q.st = SBAU_IDLE; next_q.pfx = 2'h0;
            next_q.busy = 1'b0; next_q.illegal = 1'b1;
          end
        end
      end
      SBAU_EXEC:
      begin
        if (q.cnt != 5'h00)
          next_q.cnt = 5'(q.cnt - 5'h01);
        else
        begin
          next_q.st   = SBAU_IDLE;
          next_q.pfx  = 2'h0;
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
          unique case (q.dst)
            3'h0: next_q.r_gen1 = res;
            3'h1: next_q.r_gen2 = res;
            3'h2: next_q.r_ptr = res;
            3'h3: next_q.r_stk = res;
            3'h4: next_q.r_idx1 = res;
            default: next_q.r_idx2 = res;
          endcase
          if (q.kind != SBAU_K_INC && q.kind != SBAU_K_DEC)
          begin
            next_q.flags[SBAU_F_H] = low13[12];
            next_q.flags[SBAU_F_C] = sum17[16];
            next_q.flags[SBAU_F_N] = (q.kind == SBAU_K_SUBB);
            if (q.kind != SBAU_K_ADD)
            begin
              next_q.flags[SBAU_F_S] = res[15];
              next_q.flags[SBAU_F_Z] = (res == 16'h0000);
              next_q.flags[SBAU_F_PV] = (q.kind == SBAU_K_ADC)
                ? (a_val[15] == b_val[15]) && (res[15] != a_val[15])
                : (a_val[15] != b_val[15]) && (res[15] != a_val[15]);
            end
          end
        end
      end
      default: next_q.st = SBAU_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q          <= '0;
      q.st       <= SBAU_IDLE;
      q.kind     <= SBAU_K_ADD;
      q.r_gen1   <= SBAU_REG_RST;
      q.flags    <= SBAU_FLAG_RST;
    end
    else
      q <= next_q;
  end

  assign busy                 = q.busy;
  assign done                 = q.done;
  assign illegal              = q.illegal;
  assign m_cycles             = q.m_cycles;
  assign t_states             = q.t_states;
  assign first_general_pair   = q.r_gen1;
  assign second_general_pair  = q.r_gen2;
  assign primary_pointer_pair = q.r_ptr;
  assign stack_pointer        = q.r_stk;
  assign first_index_reg      = q.r_idx1;
  assign second_index_reg     = q.r_idx2;
  assign flags                = q.flags;

  AST_ADD_TIME: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_valid && q.st == SBAU_IDLE && op_byte[7:6] == 2'h0 && op_byte[3:0] == 4'h9
    |-> ##12 done) else $error("plain add not done after 11 states");
  AST_INC_TIME: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_valid && q.st == SBAU_IDLE && op_byte[7:6] == 2'h0 && op_byte[3:0] == 4'h3
    |=> !done[*6] ##1 done) else $error("pair increment not done after 6 states");
  AST_INC_NOFLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
    q.st == SBAU_EXEC && q.cnt == 5'h00 && q.kind inside {SBAU_K_INC, SBAU_K_DEC}
    |=> $stable(flags)) else $error("increment changed flags");
  AST_ADD_KEEP_SZP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    q.st == SBAU_EXEC && q.cnt == 5'h00 && q.kind == SBAU_K_ADD
    |=> $stable(flags[5:4]) && $stable(flags[SBAU_F_PV]) && !flags[SBAU_F_N])
    else $error("plain add disturbed kept flags");
  AST_SUBB_N: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done && $past(q.kind) == SBAU_K_SUBB |-> flags[SBAU_F_N])
    else $error("borrow subtract left subtract flag clear");
  AST_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done && $past(q.kind) inside {SBAU_K_ADC, SBAU_K_SUBB}
    |-> flags[SBAU_F_Z] == ($past(res) == 16'h0000)) else $error("zero flag wrong");
  AST_CARRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done && $past(q.kind) == SBAU_K_ADD |-> flags[SBAU_F_C] == $past(sum17[16]))
    else $error("carry flag wrong");
  AST_IDX_TIME: assert property (@(posedge ref_clk) disable iff (sys_rst)
    q.st == SBAU_PFX && q.pfx[1] && op_valid && op_byte == SBAU_OP_IDX_INC
    |-> ##7 done) else $error("index increment timing wrong");
  AST_EXT_TIME: assert property (@(posedge ref_clk) disable iff (sys_rst)
    q.st == SBAU_PFX && q.pfx == 2'h1 && op_valid && op_byte[7:6] == 2'h1
    && op_byte[3:0] == 4'hA |-> ##12 done) else $error("carry add timing wrong");

  COV_ADD: cover property (@(posedge ref_clk) done && $past(q.kind) == SBAU_K_ADD);
  COV_SUBB: cover property (@(posedge ref_clk) done && $past(q.kind) == SBAU_K_SUBB);
  COV_IDX: cover property (@(posedge ref_clk) done && $past(q.dst) == 3'h5);

endmodule // sbau_unit

// >>> sim/sixteen_bit_arith_unit_tb.sv
// Testbench for the 16-bit arithmetic unit: builds values from reset by
// inc/dec, then checks carry adds, borrow subtracts, adds, refusals, timing.
// Assumes registers clear on reset; the unit has no load port.
`timescale 1ns/1ps

module sixteen_bit_arith_unit_tb;
  import sbau_pkg::*;
  logic        ref_clk;
  logic        sys_rst;
  logic        op_valid;
  logic [7:0]  op_byte;
  logic        busy;
  logic        done;
  logic        illegal;
  logic [2:0]  m_cycles;
  logic [4:0]  t_states;
  logic [15:0] r [6];
  logic [5:0]  flags;
  logic [15:0] e [6];
  logic [5:0]  ef;
  int          errors;
  int          checks_done;

  sbau_unit dut (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .op_valid             (op_valid),
    .op_byte              (op_byte),
    .busy                 (busy),
    .done                 (done),
    .illegal              (illegal),
    .m_cycles             (m_cycles),
    .t_states             (t_states),
    .first_general_pair   (r[0]),
    .second_general_pair  (r[1]),
    .primary_pointer_pair (r[2]),
    .stack_pointer        (r[3]),
    .first_index_reg      (r[4]),
    .second_index_reg     (r[5]),
    .flags                (flags)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_state();
    for (int i = 0; i < 6; i++)
      cmp($sformatf("reg%0d", i), e[i], r[i]);
    cmp("flags", {10'h000, ef}, {10'h000, flags});
  endtask

  // Kinds: 0 add, 1 carry add, 2 borrow subtract, 3 inc, 4 dec
  task automatic model(input int k, input int d, input logic [1:0] p,
                       output logic [7:0] pf, output logic [7:0] op,
                       output logic [4:0] t, output logic [2:0] m);
    logic [16:0] s;
    logic [12:0] h;
    logic [15:0] a;
    logic [15:0] b;
    logic        c;
    logic [3:0]  lo;
    a = e[d];
    b = (p == SBAU_PAIR_PTR) ? e[d] : e[p];
    c = (k == 1 || k == 2) ? ef[SBAU_F_C] : 1'b0;
    pf = (d == 4) ? SBAU_PFX_IDX1 : (d == 5) ? SBAU_PFX_IDX2 :
         (k == 1 || k == 2) ? SBAU_PFX_EXT : 8'h00;
    lo = (k == 0) ? 4'h9 : (k == 1) ? 4'hA : (k == 2) ? 4'h2 : (k == 3) ? 4'h3 : 4'hB;
    op = {(k == 1 || k == 2) ? 2'b01 : 2'b00, p, lo};
    if (d > 3 && k > 2)
      op = (k == 3) ? SBAU_OP_IDX_INC : SBAU_OP_IDX_DEC;
    t = (k == 1 || k == 2) ? SBAU_T_CARRY : (k == 0) ?
        ((d > 3) ? SBAU_T_IDX_ADD : SBAU_T_ADD) : ((d > 3) ? SBAU_T_IDX_ID : SBAU_T_INCDEC);
    m = (k == 1 || k == 2) ? SBAU_M_LONG : (k == 0) ?
        ((d > 3) ? SBAU_M_LONG : SBAU_M_ADD) : ((d > 3) ? SBAU_M_IDX_ID : SBAU_M_INCDEC);
    if (k == 2)
    begin
      s = {1'b0, a} - {1'b0, b} - {16'h0000, c};
      h = {1'b0, a[11:0]} - {1'b0, b[11:0]} - {12'h000, c};
    end
    else
    begin
      s = {1'b0, a} + {1'b0, b} + {16'h0000, c};
      h = {1'b0, a[11:0]} + {1'b0, b[11:0]} + {12'h000, c};
    end
    if (k < 3)
    begin
      ef[SBAU_F_C] = s[16];
      ef[SBAU_F_H] = h[12];
      ef[SBAU_F_N] = (k == 2);
      if (k > 0)
      begin
        ef[SBAU_F_S] = s[15];
        ef[SBAU_F_Z] = (s[15:0] == 16'h0000);
        ef[SBAU_F_PV] = (a[15] == (b[15] ^ (k == 2))) && (s[15] != a[15]);
      end
      e[d] = s[15:0];
    end
    else
      e[d] = (k == 3) ? e[d] + 16'h0001 : e[d] - 16'h0001;
  endtask

  task automatic send(input logic [7:0] b);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_byte  = b;
    @(negedge ref_clk);
    op_valid = 1'b0;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 40)
      begin
        errors++;
        tally_and_finish();
      end
    end
  endtask

  task automatic exec(input int k, input int d, input logic [1:0] p);
    logic [7:0] pf;
    logic [7:0] op;
    logic [4:0] t;
    logic [2:0] m;
    int         n;
    int         lat;
    model(k, d, p, pf, op, t, m);
    lat = (pf != 8'h00) ? int'(t) - 4 : int'(t);
    if (pf != 8'h00)
      send(pf);
    send(op);
    wait_done(n);
    cmp("latency", 16'(lat), 16'(n));
    cmp("t_states", {11'h000, t}, {11'h000, t_states});
    cmp("m_cycles", {13'h0000, m}, {13'h0000, m_cycles});
    check_state();
  endtask

  task automatic t_build();
    exec(4, 0, 2'h0);
    exec(4, 1, 2'h1);
    exec(3, 3, 2'h3);
    exec(4, 4, 2'h0);
    exec(3, 5, 2'h0);
    exec(3, 2, 2'h2);
    $display("test build done");
  endtask

  task automatic t_adcsbc();
    for (int p = 0; p < 4; p++)
      exec(1, 2, p[1:0]);
    for (int p = 0; p < 4; p++)
      exec(2, 2, p[1:0]);
    $display("test carry add and borrow subtract done");
  endtask

  task automatic t_add();
    for (int d = 2; d < 6; d++)
      for (int p = 0; p < 4; p++)
        if (d != 3)
          exec(0, d, p[1:0]);
    $display("test add done");
  endtask

  task automatic t_keep();
    for (int i = 0; i < 6; i++)
    begin
      exec(3, i, i[1:0]);
      exec(4, i, i[1:0]);
    end
    $display("test inc dec done");
  endtask

  task automatic t_ignore();
    logic [7:0] pf;
    logic [7:0] op;
    logic [4:0] t;
    logic [2:0] m;
    int         n;
    model(0, 2, 2'h1, pf, op, t, m);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_byte  = op;
    @(negedge ref_clk);
    cmp("busy", 16'h0001, {15'h0000, busy});
    op_byte = 8'h03;
    @(negedge ref_clk);
    op_valid = 1'b0;
    wait_done(n);
    cmp("latency", {11'h000, t}, 16'(n + 1));
    repeat (8) @(negedge ref_clk);
    check_state();
    $display("test ignore while busy done");
  endtask

  task automatic t_illegal();
    logic [7:0] tbl [8];
    logic       got;
    tbl = '{8'hDD, 8'hDD, 8'hFD, 8'hED, 8'h00, 8'h00, 8'hED, 8'h09};
    for (int i = 0; i < 8; i += 2)
    begin
      if (tbl[i] != 8'h00)
        send(tbl[i]);
      send(tbl[i + 1]);
      got = 1'b0;
      for (int j = 0; j < 4 && !got; j++)
      begin
        got = (illegal === 1'b1);
        @(negedge ref_clk);
      end
      cmp("illegal", 16'h0001, {15'h0000, got});
      check_state();
    end
    $display("test illegal done");
  endtask

  initial
  begin
    errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    op_valid = 1'b0;
    op_byte = 8'h00;
    ef = 6'h00;
    foreach (e[i])
      e[i] = 16'h0000;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    check_state();
    $display("test reset done");
    t_build();
    t_adcsbc();
    t_add();
    t_keep();
    t_ignore();
    t_illegal();
    tally_and_finish();
  end
endmodule // sixteen_bit_arith_unit_tb
